// ==== sfpc_pkg.sv ====
// Shared constants for both ends of the serial flash command frame link.
// Assumes a 25 MHz system clock on both ends.
package sfpc_pkg;

	// Frame layout: opcode, then dummy, page and byte/buffer fields, MSB first
	localparam int OPC_W   = 8;
	localparam int DUMMY_W = 4;
	localparam int PAGE_W  = 11;
	localparam int BYTE_W  = 9;
	localparam int HDR_W   = 32;
	localparam logic [5:0] HDR_BITS  = 6'h20;
	localparam logic [5:0] HDR_LAST  = 6'h1F;
	localparam logic [7:0] HDR_BITS8 = 8'h20;
	localparam logic [3:0] DUMMY_VAL = 4'h0;

	// Interface modes
	localparam logic MODE0    = 1'b0;
	localparam logic MODE3    = 1'b1;
	localparam logic RST_MODE = MODE3;

	// Opcodes whose page bits are dummy
	localparam logic [7:0] OPC_BUF_A = 8'hD4;
	localparam logic [7:0] OPC_BUF_B = 8'hD6;
	localparam logic [7:0] OPC_BUF_C = 8'hD1;
	localparam logic [7:0] OPC_BUF_D = 8'h84;
	localparam logic [7:0] OPC_BUF_E = 8'h87;

	// Timing
	localparam int CLK_HZ        = 25_000_000;
	localparam int SEL_DELAY_US  = 70;
	localparam int PE_DELAY_MS   = 3;
	localparam int SEL_DELAY_CYC = (SEL_DELAY_US * CLK_HZ + 999_999) / 1_000_000;
	localparam int PE_DELAY_CYC  = (PE_DELAY_MS * CLK_HZ) / 1_000;
	localparam int CNT_W         = 17;
	localparam logic [CNT_W-1:0] CNT_ZERO = 17'h00000;
	localparam logic [CNT_W-1:0] SEL_LAST = CNT_W'(SEL_DELAY_CYC - 1);

	// Host serial clock: half period in system cycles is DIV_LAST + 1
	localparam logic [2:0] DIV_LAST = 3'h7;

	function automatic logic page_unused(input logic [7:0] opc);
		return (opc == OPC_BUF_A) || (opc == OPC_BUF_B) || (opc == OPC_BUF_C) ||
			(opc == OPC_BUF_D) || (opc == OPC_BUF_E);
	endfunction

endpackage

// ==== sfpc_link_if.sv ====
// Serial link between the host controller and the flash command end.
// Assumes the testbench instantiates it once and hands one modport to each end.
interface sfpc_link_if;
	logic cs_n;
	logic sck;
	logic si;
	logic so;
	logic so_oe;
	logic so_wire;

	// Undriven data output reads as the pull-up level
	assign so_wire = so_oe ? so : 1'b1;

	modport dev
	(
		input  cs_n,
		input  sck,
		input  si,
		output so,
		output so_oe
	);

	modport host
	(
		output cs_n,
		output sck,
		output si,
		input  so_wire
	);
endinterface

// ==== sfpc_dev.sv ====
// Device end: decodes framed instructions on the serial link.
// Assumes sck is the link clock made by the host and may stop between frames.
// Function
// - Default to mode 3 after any reset
// - Output stays undriven until data is required
// - Instruction starts only after select falls
// - Select falling edge samples clock idle level
// - Host waits 70 us before first select
// - Commands ignored while reset is active
// - Enter standby after power-up completes
// - Program or erase waits up to 3 ms
// - Address: dummy, page, then byte fields
module sfpc_dev
#(
	parameter int PE_DELAY_CYC = sfpc_pkg::PE_DELAY_CYC
)
(
	// System clock domain
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_ce,
	// Serial link
	sfpc_link_if.dev         link,
	// Reply data for the bytes after the header
	input  wire logic        i_reply_en,
	input  wire logic [7:0]  i_reply_data,
	// Status and decoded instruction
	output logic             o_ready,
	output logic             o_pe_allowed,
	output logic             o_cmd_valid,
	output logic             o_mode,
	output logic             o_page_dummy,
	output logic [7:0]       o_opcode,
	output logic [10:0]      o_page,
	output logic [8:0]       o_byte
);

	localparam logic [sfpc_pkg::CNT_W-1:0] PE_LAST =
		sfpc_pkg::CNT_W'(PE_DELAY_CYC - 1);

	// Link rising-edge state, all but the held header word cleared whenever select is high
	logic [5:0]  bit_cnt_reg;
	logic [5:0]  bit_cnt_next;
	logic [31:0] hdr_sh_reg;
	logic [31:0] hdr_sh_next;
	logic        hdr_done_reg;
	logic        hdr_done_next;
	logic [2:0]  go_sync_reg;
	logic [2:0]  go_sync_next;
	logic [31:0] hdr_hold_reg;
	logic [31:0] hdr_hold_next;

	// Link falling-edge state
	logic [2:0]  rep_bit_reg;
	logic [2:0]  rep_bit_next;
	logic [7:0]  rep_sh_reg;
	logic [7:0]  rep_sh_next;
	logic        so_reg;
	logic        so_next;
	logic        so_oe_reg;
	logic        so_oe_next;
	logic        mode_cap_reg;

	// System domain state
	logic [2:0]  rdy_s_reg;
	logic [2:0]  rdy_s_next;
	logic        seen_reg;
	logic        seen_next;
	logic        ready_reg;
	logic        ready_next;
	logic [16:0] pe_cnt_reg;
	logic [16:0] pe_cnt_next;
	logic        pe_ok_reg;
	logic        pe_ok_next;
	logic        rep_go_reg;
	logic        rep_go_next;
	logic [7:0]  rep_data_reg;
	logic [7:0]  rep_data_next;
	logic        cmd_valid_reg;
	logic        cmd_valid_next;
	logic        mode_reg;
	logic        mode_next;
	logic        dummy_reg;
	logic        dummy_next;
	logic [7:0]  opcode_reg;
	logic [7:0]  opcode_next;
	logic [10:0] page_reg;
	logic [10:0] page_next;
	logic [8:0]  byte_reg;
	logic [8:0]  byte_next;

	// Header shifter: counts rising edges and saturates once the header is in
	always_comb
	begin
		bit_cnt_next  = bit_cnt_reg;
		hdr_sh_next   = hdr_sh_reg;
		hdr_done_next = hdr_done_reg;
		hdr_hold_next = hdr_hold_reg;
		go_sync_next  = {go_sync_reg[1:0], rep_go_reg};
		if (bit_cnt_reg < sfpc_pkg::HDR_BITS)
		begin
			bit_cnt_next = bit_cnt_reg + 6'h01;
			hdr_sh_next  = {hdr_sh_reg[30:0], link.si};
		end
		if (bit_cnt_reg == sfpc_pkg::HDR_LAST)
		begin
			hdr_hold_next = {hdr_sh_reg[30:0], link.si};
			hdr_done_next = 1'b1;
		end
	end

	// Select high ends the frame; a partial header never raises done
	always_ff @(posedge link.sck or posedge link.cs_n)
	begin
		if (link.cs_n)
		begin
			bit_cnt_reg  <= 6'h00;
			hdr_sh_reg   <= 32'h00000000;
			hdr_done_reg <= 1'b0;
			go_sync_reg  <= 3'h0;
		end
		else
		begin
			bit_cnt_reg  <= bit_cnt_next;
			hdr_sh_reg   <= hdr_sh_next;
			hdr_done_reg <= hdr_done_next;
			go_sync_reg  <= go_sync_next;
		end
	end

	// Header word held for the system side; stable until the next full header
	always_ff @(posedge link.sck)
	begin
		hdr_hold_reg <= hdr_hold_next;
	end

	// Mode of this instruction is the clock idle level as select falls
	always_ff @(negedge link.cs_n)
	begin
		mode_cap_reg <= link.sck;
	end

	// Reply shifter drives only after a full header and only when enabled
	always_comb
	begin
		rep_bit_next = rep_bit_reg;
		rep_sh_next  = rep_sh_reg;
		so_next      = so_reg;
		so_oe_next   = so_oe_reg;
		if (hdr_done_reg && go_sync_reg[2] && go_sync_reg[1]) // Enable counts once both agree
		begin
			so_oe_next   = 1'b1;
			rep_bit_next = rep_bit_reg + 3'h1;
			if (rep_bit_reg == 3'h0)
			begin
				so_next     = rep_data_reg[7];
				rep_sh_next = {rep_data_reg[6:0], 1'b0};
			end
			else
			begin
				so_next     = rep_sh_reg[7];
				rep_sh_next = {rep_sh_reg[6:0], 1'b0};
			end
		end
	end

	// Output changes on falling edges so the host samples it on rising ones
	always_ff @(negedge link.sck or posedge link.cs_n)
	begin
		if (link.cs_n)
		begin
			rep_bit_reg <= 3'h0;
			rep_sh_reg  <= 8'h00;
			so_reg      <= 1'b1;
			so_oe_reg   <= 1'b0;
		end
		else
		begin
			rep_bit_reg <= rep_bit_next;
			rep_sh_reg  <= rep_sh_next;
			so_reg      <= so_next;
			so_oe_reg   <= so_oe_next;
		end
	end

	assign link.so    = so_reg;
	assign link.so_oe = so_oe_reg;

	// System side: header-done level crosses through three flops
	always_comb
	begin
		rdy_s_next     = {rdy_s_reg[1:0], hdr_done_reg};
		seen_next      = (rdy_s_reg[1] == rdy_s_reg[2]) ? rdy_s_reg[2] : seen_reg;
		ready_next     = 1'b1;
		pe_cnt_next    = pe_cnt_reg;
		pe_ok_next     = pe_ok_reg | (pe_cnt_reg == PE_LAST);
		rep_go_next    = i_reply_en & ready_reg;
		rep_data_next  = i_reply_data;
		cmd_valid_next = 1'b0;
		mode_next      = mode_reg;
		dummy_next     = dummy_reg;
		opcode_next    = opcode_reg;
		page_next      = page_reg;
		byte_next      = byte_reg;
		if (pe_cnt_reg != PE_LAST)
		begin
			pe_cnt_next = pe_cnt_reg + 17'h00001;
		end
		// A new header counts once the two later flops agree on high
		if ((rdy_s_reg[1] == rdy_s_reg[2]) && rdy_s_reg[2] && !seen_reg && ready_reg)
		begin
			cmd_valid_next = 1'b1;
			mode_next      = mode_cap_reg;
			opcode_next    = hdr_hold_reg[31:24];
			byte_next      = hdr_hold_reg[8:0];
			dummy_next     = sfpc_pkg::page_unused(hdr_hold_reg[31:24]);
			page_next      = dummy_next ? 11'h000 : hdr_hold_reg[19:9];
		end
	end

	// Reset holds everything idle; no header is reported while it lasts
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			rdy_s_reg     <= 3'h0;
			seen_reg      <= 1'b1;
			ready_reg     <= 1'b0;
			pe_cnt_reg    <= sfpc_pkg::CNT_ZERO;
			pe_ok_reg     <= 1'b0;
			rep_go_reg    <= 1'b0;
			rep_data_reg  <= 8'h00;
			cmd_valid_reg <= 1'b0;
			mode_reg      <= sfpc_pkg::RST_MODE;
			dummy_reg     <= 1'b0;
			opcode_reg    <= 8'h00;
			page_reg      <= 11'h000;
			byte_reg      <= 9'h000;
		end
		else if (i_ce)
		begin
			rdy_s_reg     <= rdy_s_next;
			seen_reg      <= seen_next;
			ready_reg     <= ready_next;
			pe_cnt_reg    <= pe_cnt_next;
			pe_ok_reg     <= pe_ok_next;
			rep_go_reg    <= rep_go_next;
			rep_data_reg  <= rep_data_next;
			cmd_valid_reg <= cmd_valid_next;
			mode_reg      <= mode_next;
			dummy_reg     <= dummy_next;
			opcode_reg    <= opcode_next;
			page_reg      <= page_next;
			byte_reg      <= byte_next;
		end
	end

	// Outputs
	assign o_ready      = ready_reg;
	assign o_pe_allowed = pe_ok_reg;
	assign o_cmd_valid  = cmd_valid_reg;
	assign o_mode       = mode_reg;
	assign o_page_dummy = dummy_reg;
	assign o_opcode     = opcode_reg;
	assign o_page       = page_reg;
	assign o_byte       = byte_reg;

endmodule

// ==== sfpc_host.sv ====
// Host end: frames one instruction per request and collects reply bytes.
// Assumes the device end samples on rising sck and drives on falling sck.
module sfpc_host
#(
	parameter int PE_DELAY_CYC = sfpc_pkg::PE_DELAY_CYC
)
(
	// System clock domain
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_ce,
	// Serial link
	sfpc_link_if.host        link,
	// Request
	input  wire logic        i_start,
	input  wire logic [7:0]  i_opcode,
	input  wire logic [10:0] i_page,
	input  wire logic [8:0]  i_byte,
	input  wire logic        i_mode,
	input  wire logic        i_pe,
	input  wire logic [3:0]  i_rd_bytes,
	// Status and reply
	output logic             o_ready,
	output logic             o_busy,
	output logic             o_done,
	output logic             o_rd_valid,
	output logic [7:0]       o_rd_data
);

	localparam logic [sfpc_pkg::CNT_W-1:0] PE_LAST =
		sfpc_pkg::CNT_W'(PE_DELAY_CYC - 1);

	typedef enum {H_IDLE, H_ARM, H_SEL, H_LOW, H_HIGH, H_END, H_GAP} sfpc_hst_t;

	sfpc_hst_t   st_reg, st_next;
	logic [2:0]  div_reg, div_next;
	logic [16:0] pwr_reg, pwr_next;
	logic        ready_reg, ready_next;
	logic        pe_ok_reg, pe_ok_next;
	logic [2:0]  so_s_reg, so_s_next;
	logic        so_f_reg, so_f_next;
	logic [31:0] tx_reg, tx_next;
	logic [7:0]  rx_reg, rx_next;
	logic [2:0]  rx_cnt_reg, rx_cnt_next;
	logic [7:0]  idx_reg, idx_next;
	logic [7:0]  total_reg, total_next;
	logic        mode_reg, mode_next;
	logic        pe_reg, pe_next;
	logic        cs_n_reg, cs_n_next;
	logic        sck_reg, sck_next;
	logic        si_reg, si_next;
	logic        busy_reg, busy_next;
	logic        done_reg, done_next;
	logic        rdv_reg, rdv_next;
	logic [7:0]  rdd_reg, rdd_next;
	logic        tick;

	// Free-running divider; every link edge but the idle-level set in H_IDLE falls on a wrap
	assign tick = (div_reg == sfpc_pkg::DIV_LAST);

	// Frame sequencer
	always_comb
	begin
		st_next     = st_reg;
		div_next    = div_reg + 3'h1;
		pwr_next    = pwr_reg;
		ready_next  = (pwr_reg >= sfpc_pkg::SEL_LAST);
		pe_ok_next  = (pwr_reg == PE_LAST);
		so_s_next   = {so_s_reg[1:0], link.so_wire};
		so_f_next   = (so_s_reg[1] == so_s_reg[2]) ? so_s_reg[2] : so_f_reg;
		tx_next     = tx_reg;
		rx_next     = rx_reg;
		rx_cnt_next = rx_cnt_reg;
		idx_next    = idx_reg;
		total_next  = total_reg;
		mode_next   = mode_reg;
		pe_next     = pe_reg;
		cs_n_next   = cs_n_reg;
		sck_next    = sck_reg;
		si_next     = si_reg;
		busy_next   = busy_reg;
		done_next   = 1'b0;
		rdv_next    = 1'b0;
		rdd_next    = rdd_reg;
		if (pwr_reg != PE_LAST)
		begin
			pwr_next = pwr_reg + 17'h00001;
		end
		case (st_reg)
			H_IDLE:
			begin
				if (i_start && ready_reg)
				begin
					tx_next    = {i_opcode, sfpc_pkg::DUMMY_VAL, i_page, i_byte};
					total_next = sfpc_pkg::HDR_BITS8 + {1'b0, i_rd_bytes, 3'h0};
					idx_next   = 8'h00;
					mode_next  = i_mode;
					pe_next    = i_pe;
					sck_next   = i_mode; // Idle level tells the device the mode
					busy_next  = 1'b1;
					st_next    = H_ARM;
				end
			end
			H_ARM:
			begin
				if (tick && (!pe_reg || pe_ok_reg))
				begin
					cs_n_next = 1'b0;
					st_next   = H_SEL;
				end
			end
			H_SEL:
			begin
				if (tick)
				begin
					sck_next = 1'b0;
					si_next  = tx_reg[31];
					tx_next  = {tx_reg[30:0], 1'b0};
					st_next  = H_LOW;
				end
			end
			H_LOW:
			begin
				if (tick)
				begin
					sck_next = 1'b1;
					idx_next = idx_reg + 8'h01;
					if (idx_reg >= sfpc_pkg::HDR_BITS8)
					begin
						rx_next     = {rx_reg[6:0], so_f_reg};
						rx_cnt_next = rx_cnt_reg + 3'h1;
						if (rx_cnt_reg == 3'h7)
						begin
							rdv_next = 1'b1;
							rdd_next = {rx_reg[6:0], so_f_reg};
						end
					end
					st_next = H_HIGH;
				end
			end
			H_HIGH:
			begin
				if (tick)
				begin
					if (idx_reg == total_reg)
					begin
						sck_next = mode_reg;
						st_next  = H_END;
					end
					else
					begin
						sck_next = 1'b0;
						si_next  = tx_reg[31];
						tx_next  = {tx_reg[30:0], 1'b0};
						st_next  = H_LOW;
					end
				end
			end
			H_END:
			begin
				if (tick)
				begin
					cs_n_next   = 1'b1;
					rx_cnt_next = 3'h0;
					st_next     = H_GAP;
				end
			end
			H_GAP:
			begin
				if (tick)
				begin
					done_next = 1'b1;
					busy_next = 1'b0;
					st_next   = H_IDLE;
				end
			end
			default:
			begin
				st_next = H_IDLE;
			end
		endcase
	end

	// Registers; select starts high so the first instruction sees a fall
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			st_reg     <= H_IDLE;
			div_reg    <= 3'h0;
			pwr_reg    <= sfpc_pkg::CNT_ZERO;
			ready_reg  <= 1'b0;
			pe_ok_reg  <= 1'b0;
			so_s_reg   <= 3'h7;
			so_f_reg   <= 1'b1;
			tx_reg     <= 32'h00000000;
			rx_reg     <= 8'h00;
			rx_cnt_reg <= 3'h0;
			idx_reg    <= 8'h00;
			total_reg  <= 8'h00;
			mode_reg   <= sfpc_pkg::RST_MODE;
			pe_reg     <= 1'b0;
			cs_n_reg   <= 1'b1;
			sck_reg    <= sfpc_pkg::RST_MODE;
			si_reg     <= 1'b0;
			busy_reg   <= 1'b0;
			done_reg   <= 1'b0;
			rdv_reg    <= 1'b0;
			rdd_reg    <= 8'h00;
		end
		else if (i_ce)
		begin
			st_reg     <= st_next;
			div_reg    <= div_next;
			pwr_reg    <= pwr_next;
			ready_reg  <= ready_next;
			pe_ok_reg  <= pe_ok_next;
			so_s_reg   <= so_s_next;
			so_f_reg   <= so_f_next;
			tx_reg     <= tx_next;
			rx_reg     <= rx_next;
			rx_cnt_reg <= rx_cnt_next;
			idx_reg    <= idx_next;
			total_reg  <= total_next;
			mode_reg   <= mode_next;
			pe_reg     <= pe_next;
			cs_n_reg   <= cs_n_next;
			sck_reg    <= sck_next;
			si_reg     <= si_next;
			busy_reg   <= busy_next;
			done_reg   <= done_next;
			rdv_reg    <= rdv_next;
			rdd_reg    <= rdd_next;
		end
	end

	assign link.cs_n  = cs_n_reg;
	assign link.sck   = sck_reg;
	assign link.si    = si_reg;
	assign o_ready    = ready_reg;
	assign o_busy     = busy_reg;
	assign o_done     = done_reg;
	assign o_rd_valid = rdv_reg;
	assign o_rd_data  = rdd_reg;

endmodule

// ==== sfpc_assertions.sv ====
// Checker for the serial link between the host end and the device end.
// Assumes every link signal settles between i_clk edges; i_sys_rst is the host reset.
module sfpc_assertions
(
	// System clock and host reset
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	// Link signals
	input  wire logic cs_n,
	input  wire logic sck,
	input  wire logic si,
	input  wire logic so_oe
);
	logic [16:0] wait_reg;
	logic [16:0] wait_next;
	logic [7:0]  bits_reg;
	logic [7:0]  bits_next;
	logic        sck_reg;

	// Cycles since reset saturate so a long run cannot wrap into a false early select
	always_comb
	begin
		wait_next = (wait_reg == 17'h1FFFF) ? wait_reg : wait_reg + 17'h00001;
		bits_next = cs_n ? 8'h00 : bits_reg + {7'h00, sck & ~sck_reg};
	end

	// Counters register only; link bits clear while deselected
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			wait_reg <= 17'h00000;
			bits_reg <= 8'h00;
			sck_reg  <= 1'b1;
		end
		else
		begin
			wait_reg <= wait_next;
			bits_reg <= bits_next;
			sck_reg  <= sck;
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	sel_wait_a: assert property ($fell(cs_n) |-> wait_reg >= 17'(sfpc_pkg::SEL_DELAY_CYC))
		else $error("select fell too soon after reset");
	sel_hold_a: assert property ($fell(cs_n) |-> !cs_n [*8])
		else $error("select not held after falling");
	idle_level_a: assert property ($fell(cs_n) |-> $stable(sck))
		else $error("clock moved as select fell");
	half_period_a: assert property ($changed(sck) && !cs_n |=> $stable(sck) [*7])
		else $error("link clock half period too short");
	si_stable_a: assert property ($rose(sck) && !cs_n |-> $stable(si))
		else $error("data changed at sampling edge");
	whole_bytes_a: assert property ($rose(cs_n) |-> bits_reg >= 8'h20 && bits_reg[2:0] == 3'h0)
		else $error("frame not header plus whole bytes");
	out_after_hdr_a: assert property ($rose(so_oe) |-> bits_reg >= 8'h20)
		else $error("output driven before header complete");
	out_release_a: assert property (cs_n && $past(cs_n) |-> !so_oe)
		else $error("output driven while deselected");

	// Main scenarios
	cover property ($fell(cs_n) && !sck);
	cover property ($fell(cs_n) && sck);
	cover property ($rose(so_oe));
endmodule

// ==== serial_flash_powerup_cmd_frame_tb.sv ====
// Testbench joining the host end and the device end over one link.
// Assumes both ends run on one 25 MHz clock with separate resets.
`define CHK(got, exp) \
	begin \
		tests_run++; \
		if ((got) !== (exp)) \
		begin \
			failures++; \
			$display("BAD %0t got %h expected %h", $time, got, exp); \
		end \
	end
module serial_flash_powerup_cmd_frame_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PE = 2000;
	logic        clk = 1'b0;
	logic        dev_rst = 1'b1;
	logic        host_rst = 1'b1;
	logic        start = 1'b0;
	logic [7:0]  op = 8'h00;
	logic [10:0] pg = 11'h000;
	logic [8:0]  by = 9'h000;
	logic        md = 1'b1;
	logic        pe = 1'b0;
	logic [3:0]  nrd = 4'h0;
	logic        ren = 1'b0;
	logic [7:0]  rdat = 8'h00;
	logic        d_ready, d_pe, d_cmd, d_mode, d_pdum, h_ready, h_busy, h_done, h_rv, cs_prev;
	logic [7:0]  d_op, h_rd;
	logic [10:0] d_pg;
	logic [8:0]  d_by;
	logic [30:0] cmd_q[$];
	logic [7:0]  rd_q[$];
	int          failures = 0;
	int          tests_run = 0;
	int          seed = 35;
	int          cyc = 0;
	int          last_fall = 0;
	int          k;

	sfpc_link_if sfpc_link_if_inst();
	sfpc_dev #(.PE_DELAY_CYC(PE)) sfpc_dev_inst (.i_clk(clk), .i_sys_rst(dev_rst), .i_ce(1'b1),
		.link(sfpc_link_if_inst), .i_reply_en(ren), .i_reply_data(rdat), .o_ready(d_ready),
		.o_pe_allowed(d_pe), .o_cmd_valid(d_cmd), .o_mode(d_mode), .o_page_dummy(d_pdum),
		.o_opcode(d_op), .o_page(d_pg), .o_byte(d_by));
	sfpc_host #(.PE_DELAY_CYC(PE)) sfpc_host_inst (.i_clk(clk), .i_sys_rst(host_rst), .i_ce(1'b1),
		.link(sfpc_link_if_inst), .i_start(start), .i_opcode(op), .i_page(pg), .i_byte(by),
		.i_mode(md), .i_pe(pe), .i_rd_bytes(nrd), .o_ready(h_ready), .o_busy(h_busy),
		.o_done(h_done), .o_rd_valid(h_rv), .o_rd_data(h_rd));
	sfpc_assertions sfpc_assertions_inst (.i_clk(clk), .i_sys_rst(host_rst),
		.cs_n(sfpc_link_if_inst.cs_n), .sck(sfpc_link_if_inst.sck), .si(sfpc_link_if_inst.si),
		.so_oe(sfpc_link_if_inst.so_oe));

	always #20 clk = ~clk;

	// Cycles since host reset, stepped on the edge that moves the design so reads never race
	always @(posedge clk)
		cyc <= host_rst ? 0 : cyc + 1;

	// Monitor on the falling edge so flop outputs have settled; every report must be noted
	always @(negedge clk)
	begin
		cs_prev <= sfpc_link_if_inst.cs_n;
		if (cs_prev === 1'b1 && sfpc_link_if_inst.cs_n === 1'b0)
			last_fall = cyc;
		if (d_cmd === 1'b1)
		begin
			if (cmd_q.size() == 0) `CHK(1'b1, 1'b0)
			else `CHK({d_mode, d_pdum, d_pe, d_op, d_pg, d_by}, cmd_q.pop_front())
		end
		if (h_rv === 1'b1)
		begin
			if (rd_q.size() == 0) `CHK(1'b1, 1'b0)
			else `CHK(h_rd, rd_q.pop_front())
		end
	end

	task automatic wait_ready();
		for (k = 0; k < 5000 && !(h_ready === 1'b1 && h_busy === 1'b0); k++)
			@(negedge clk);
	endtask

	// One framed request; note what each end should report
	task automatic send(input logic [7:0] o, input logic m, p, r, input logic [3:0] n,
		input logic note);
		logic pd;
		wait_ready();
		pd = (o == 8'hD4) || (o == 8'hD6) || (o == 8'hD1) || (o == 8'h84) || (o == 8'h87);
		op = o;
		md = m;
		pe = p;
		ren = r;
		nrd = n;
		pg = 11'($random(seed));
		by = 9'($random(seed));
		rdat = 8'($random(seed));
		start = 1'b1;
		if (note)
			cmd_q.push_back({m, pd, 1'b1, o, pd ? 11'h000 : pg, by});
		repeat (n) rd_q.push_back(r ? rdat : 8'hFF);
		@(negedge clk);
		start = 1'b0;
		`CHK(h_busy, 1'b1)
		for (k = 0; k < 8000 && h_done !== 1'b1; k++)
			@(negedge clk);
		`CHK(h_done, 1'b1)
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Watchdog sized well beyond the expected run of some eleven thousand cycles
	initial
	begin
		repeat (60000) @(negedge clk);
		failures++;
		print_verdict();
	end

	initial
	begin
		logic [7:0] ops[8];
		ops = '{8'hD2, 8'hD4, 8'hD6, 8'hD1, 8'h84, 8'h87, 8'h03, 8'h9F};
		repeat (16) @(negedge clk);
		`CHK(d_mode, sfpc_pkg::MODE3)
		`CHK(sfpc_link_if_inst.so_wire, 1'b1)
		dev_rst = 1'b0;
		host_rst = 1'b0;
		@(negedge clk);
		@(negedge clk);
		`CHK(d_ready, 1'b1)
		wait_ready();
		`CHK(cyc >= sfpc_pkg::SEL_DELAY_CYC, 1'b1)
		`CHK(d_pe, 1'b0)
		// Program request straight after power-up must hold off select
		send(8'h82, 1'b1, 1'b1, 1'b0, 4'h0, 1'b1);
		`CHK(last_fall >= PE, 1'b1)
		// Every page-dummy code and both modes, with and without reply bytes
		for (int i = 0; i < 8; i++)
			send(ops[i], i[0], 1'b0, i[1], 4'(i % 3), 1'b1);
		// Host reset mid-frame leaves a short frame that must be dropped
		wait_ready();
		op = 8'h0B;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		repeat (200) @(negedge clk);
		`CHK(sfpc_link_if_inst.cs_n, 1'b0)
		host_rst = 1'b1;
		repeat (3) @(negedge clk);
		`CHK(sfpc_link_if_inst.cs_n, 1'b1)
		host_rst = 1'b0;
		send(8'h53, 1'b0, 1'b0, 1'b1, 4'h2, 1'b1);
		// Device held in reset ignores a whole frame
		dev_rst = 1'b1;
		send(8'hD2, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0);
		dev_rst = 1'b0;
		@(negedge clk);
		`CHK(d_mode, sfpc_pkg::MODE3)
		`CHK(d_pe, 1'b0)
		`CHK(d_ready, 1'b1)
		repeat (20) @(negedge clk);
		`CHK(cmd_q.size() + rd_q.size(), 0)
		print_verdict();
	end
endmodule
